// ---- shared/dcr_consts.vh ----
`ifndef DCR_CONSTS_VH
`define DCR_CONSTS_VH
// ==========================================
// Clock ratios in system clocks per frame.
`define DCR_RATIO_128 11'd128
`define DCR_RATIO_192 11'd192
`define DCR_RATIO_256 11'd256
`define DCR_RATIO_384 11'd384
`define DCR_RATIO_512 11'd512
`define DCR_RATIO_768 11'd768
`define DCR_RATIO_1152 11'd1152
// ==========================================
// Rate mode and force encodings.
`define DCR_MODE_SINGLE 2'h0
`define DCR_MODE_DUAL 2'h1
`define DCR_MODE_QUAD 2'h2
`define DCR_FORCE_AUTO 2'h0
`define DCR_FORCE_SINGLE 2'h1
`define DCR_FORCE_DUAL 2'h2
`define DCR_FORCE_QUAD 2'h3
// ==========================================
// Oversampling ratios.
`define DCR_OSR_32 8'h20
`define DCR_OSR_64 8'h40
`define DCR_OSR_128 8'h80
`define DCR_FOSR_4 4'h4
`define DCR_FOSR_8 4'h8
// ==========================================
// Release sequence length in own clock cycles.
`define DCR_RELEASE_CYCLES 3846
// Single rate is valid only below this sample rate.
`define DCR_SINGLE_MAX_FS_HZ 50000
// Output level codes.
`define DCR_LVL_GROUND 2'h0
`define DCR_LVL_COMMON 2'h1
`define DCR_LVL_DATA 2'h2
`endif

// ---- core/dcr_sync2.v ----
// ==========================================
// Two-flop synchroniser for a bundle of levels.
module dcr_sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // Asynchronous levels
  input wire [WIDTH-1:0] async_in,
  // Synchronised levels
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_q <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // dcr_sync2

// ---- core/dcr_ctrl.v ----
// Behaviour
// - System clock is 128,192,256,384,512,768 or 1152 times the frame rate; other ratios unsupported.
// - Automatic mode: single for 512/768/1152, dual 256/384, quad 128/192.
// - Forced mode applies only to permitted pairings; quad only with 128/192.
// - Single rate modulator oversamples 128, or 64 at ratio 128/192; fs below 50 kHz.
// - Ratio 128 or 192 always selects the quad-rate filter characteristic.
// - After power-on, internal reset holds 3846 system clocks before release; the code counts 3846 of its own clock cycles.
// - Outputs sit at common mode until release, then follow the serial data.
// - Lost clock synchronisation keeps reset and power-down; regain reruns release.
// - Reset pin low asserts internal reset, clears state, enters power-down.
// - Reset pin low drives outputs to analog ground at once; the code grounds them three own clock cycles after the pin falls.
// - Reset pin high again runs the same timed release sequence.
// - Data input n feeds converters 2n-1 and 2n.
`include "dcr_consts.vh"
module dcr_ctrl #(
  parameter RELEASE_CYCLES = `DCR_RELEASE_CYCLES,
  parameter LOCK_FRAMES = 2
) (
  // Clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // Pins from the audio processor
  input wire sys_clk_in,
  input wire serial_bit_clk_in,
  input wire frame_clk_in,
  input wire serial_data_in_1_in,
  input wire serial_data_in_2_in,
  input wire serial_data_in_3_in,
  input wire serial_data_in_4_in,
  input wire ext_rst_n_in,
  // Mode override
  input wire [1:0] force_mode_in,
  // Status
  output reg [10:0] clk_ratio_out,
  output reg ratio_valid_out,
  output reg [1:0] rate_mode_out,
  output reg [7:0] oversample_ratio_out,
  output reg [3:0] filter_osr_out,
  output reg quad_filter_out,
  output reg clk_sync_out,
  output reg int_rst_out,
  output reg power_down_out,
  output reg [1:0] analog_out_level_out,
  // Per-converter data bits, converter k at bit k-1
  output reg [7:0] conv_data_out
);
  // ==========================================
  // Input synchronisers.
  wire [7:0] pin_s;
  dcr_sync2 #(.WIDTH(8)) u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    // The reset pin enters inverted so that a cleared synchroniser reads as a released pin.
    .async_in({~ext_rst_n_in, serial_data_in_4_in, serial_data_in_3_in, serial_data_in_2_in,
      serial_data_in_1_in, frame_clk_in, serial_bit_clk_in, sys_clk_in}),
    .sync_out(pin_s)
  );
  wire sck_s = pin_s[0];
  wire bck_s = pin_s[1];
  wire lr_s = pin_s[2];
  wire [3:0] din_s = pin_s[6:3];
  wire rstn_s = ~pin_s[7];

  // Supported-ratio check shared by the sync logic and the ratio_valid_out register.
  function ratio_ok;
    input [10:0] r;
    begin
      ratio_ok = (r == `DCR_RATIO_128) || (r == `DCR_RATIO_192) || (r == `DCR_RATIO_256) ||
        (r == `DCR_RATIO_384) || (r == `DCR_RATIO_512) || (r == `DCR_RATIO_768) ||
        (r == `DCR_RATIO_1152);
    end
  endfunction

  // ==========================================
  // Edge detection and ratio measurement.
  reg sck_d_q, bck_d_q, lr_d_q;
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      sck_d_q <= 1'b0;
      bck_d_q <= 1'b0;
      lr_d_q <= 1'b0;
    end else begin
      sck_d_q <= sck_s;
      bck_d_q <= bck_s;
      lr_d_q <= lr_s;
    end
  end
  wire sck_rise = sck_s & ~sck_d_q;
  wire bck_rise = bck_s & ~bck_d_q;
  wire lr_rise = lr_s & ~lr_d_q;

  reg [11:0] sck_cnt_q;
  reg [10:0] ratio_q;
  reg bck_seen_q;
  reg [1:0] lock_q;
  reg sync_q;
  wire [11:0] sck_cnt_d = sck_cnt_q + (sck_rise ? 12'h001 : 12'h000);
  // Counts own clock cycles since the last frame clock rise, so a halted system clock is still seen.
  reg [11:0] halt_cnt_q;
  always @(posedge clk_in) begin
    if (sys_rst_in || lr_rise) begin
      halt_cnt_q <= 12'h000;
    end else if (halt_cnt_q != 12'hFFF) begin
      halt_cnt_q <= halt_cnt_q + 12'h001;
    end
  end
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      sck_cnt_q <= 12'h000;
      ratio_q <= 11'h000;
      bck_seen_q <= 1'b0;
      lock_q <= 2'h0;
      sync_q <= 1'b0;
    end else if (lr_rise) begin
      sck_cnt_q <= 12'h000;
      bck_seen_q <= 1'b0;
      ratio_q <= sck_cnt_d[10:0];
      // Sync needs a supported, stable ratio and a running bit clock.
      if (ratio_ok(sck_cnt_d[10:0]) && !sck_cnt_d[11] && (sck_cnt_d[10:0] == ratio_q) &&
          (bck_seen_q || bck_rise)) begin
        if (lock_q != LOCK_FRAMES[1:0]) begin
          lock_q <= lock_q + 2'h1;
        end
        sync_q <= (lock_q + 2'h1 >= LOCK_FRAMES[1:0]);
      end else begin
        lock_q <= 2'h0;
        sync_q <= 1'b0;
      end
    end else begin
      if (bck_rise) begin
        bck_seen_q <= 1'b1;
      end
      if (sck_cnt_q == 12'hFFF || halt_cnt_q == 12'hFFF) begin
        // Frame clock or system clock halted: declare loss of sync.
        lock_q <= 2'h0;
        sync_q <= 1'b0;
      end
      if (sck_cnt_q != 12'hFFF) begin
        sck_cnt_q <= sck_cnt_d;
      end
    end
  end

  // ==========================================
  // Rate mode selection.
  reg [1:0] mode_d;
  reg [7:0] osr_d;
  reg [3:0] fosr_d;
  wire low_ratio = (ratio_q == `DCR_RATIO_128) || (ratio_q == `DCR_RATIO_192);
  wire mid_ratio = (ratio_q == `DCR_RATIO_256) || (ratio_q == `DCR_RATIO_384);
  always @* begin
    if (low_ratio) begin
      mode_d = `DCR_MODE_QUAD;
    end else if (mid_ratio) begin
      mode_d = `DCR_MODE_DUAL;
    end else begin
      mode_d = `DCR_MODE_SINGLE;
    end
    // Overrides only take effect for permitted pairings.
    if (force_mode_in == `DCR_FORCE_SINGLE) begin
      mode_d = `DCR_MODE_SINGLE;
    end else if (force_mode_in == `DCR_FORCE_DUAL && (low_ratio || mid_ratio)) begin
      mode_d = `DCR_MODE_DUAL;
    end else if (force_mode_in == `DCR_FORCE_QUAD && low_ratio) begin
      mode_d = `DCR_MODE_QUAD;
    end
    fosr_d = low_ratio ? `DCR_FOSR_4 : `DCR_FOSR_8;
    if (mode_d == `DCR_MODE_QUAD) begin
      osr_d = `DCR_OSR_32;
    end else if (mode_d == `DCR_MODE_DUAL) begin
      osr_d = `DCR_OSR_64;
    end else if (low_ratio) begin
      osr_d = `DCR_OSR_64;
    end else begin
      osr_d = `DCR_OSR_128;
    end
  end

  // ==========================================
  // Internal reset release sequence.
  localparam ST_HOLD = 1'b0;
  localparam ST_RUN = 1'b1;
  reg state_q;
  reg [11:0] rel_cnt_q;
  always @(posedge clk_in) begin
    if (sys_rst_in || !rstn_s || !sync_q) begin
      state_q <= ST_HOLD;
      rel_cnt_q <= 12'h000;
    end else begin
      case (state_q)
        ST_HOLD: begin
          if (rel_cnt_q == RELEASE_CYCLES[11:0] - 12'h001) begin
            state_q <= ST_RUN;
          end else begin
            rel_cnt_q <= rel_cnt_q + 12'h001;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // ==========================================
  // Registered outputs.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      clk_ratio_out <= 11'h000;
      ratio_valid_out <= 1'b0;
      rate_mode_out <= `DCR_MODE_SINGLE;
      oversample_ratio_out <= `DCR_OSR_128;
      filter_osr_out <= `DCR_FOSR_8;
      quad_filter_out <= 1'b0;
      clk_sync_out <= 1'b0;
      int_rst_out <= 1'b1;
      power_down_out <= 1'b1;
      analog_out_level_out <= `DCR_LVL_COMMON;
      conv_data_out <= 8'h00;
    end else begin
      clk_ratio_out <= ratio_q;
      ratio_valid_out <= ratio_ok(ratio_q);
      rate_mode_out <= mode_d;
      oversample_ratio_out <= osr_d;
      filter_osr_out <= fosr_d;
      quad_filter_out <= low_ratio;
      clk_sync_out <= sync_q;
      int_rst_out <= !rstn_s || state_q == ST_HOLD;
      power_down_out <= !rstn_s || state_q == ST_HOLD;
      if (!rstn_s) begin
        analog_out_level_out <= `DCR_LVL_GROUND;
      end else if (state_q == ST_HOLD) begin
        analog_out_level_out <= `DCR_LVL_COMMON;
      end else begin
        analog_out_level_out <= `DCR_LVL_DATA;
      end
      if (!rstn_s || state_q == ST_HOLD) begin
        conv_data_out <= 8'h00;
      end else begin
        conv_data_out <= {din_s[3], din_s[3], din_s[2], din_s[2],
          din_s[1], din_s[1], din_s[0], din_s[0]};
      end
    end
  end
endmodule // dcr_ctrl

// ---- dv/dcr_ctrl_checker.sv ----
// ==========================================
// Checker on the control ports.
module dcr_ctrl_checker #(
  parameter RELEASE_CYCLES = 3846
) (
  // Clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // Watched ports
  input wire ext_rst_n_in,
  input wire [10:0] clk_ratio_out,
  input wire ratio_valid_out,
  input wire [1:0] rate_mode_out,
  input wire [7:0] oversample_ratio_out,
  input wire [3:0] filter_osr_out,
  input wire quad_filter_out,
  input wire clk_sync_out,
  input wire int_rst_out,
  input wire power_down_out,
  input wire [1:0] analog_out_level_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [15:0] wait_q;
  // Counts cycles held in reset while locked with the pin high.
  always @(posedge clk_in) begin
    if (sys_rst_in || !int_rst_out || !clk_sync_out || !ext_rst_n_in) wait_q <= 16'h0000;
    else wait_q <= wait_q + 16'h0001;
  end
  a_pd_follows: assert property (power_down_out == int_rst_out)
    else $error("power down differs from reset");
  a_pin_ground: assert property ($fell(ext_rst_n_in) |-> ##[1:4] (analog_out_level_out == 2'h0 && int_rst_out))
    else $error("reset pin did not ground outputs");
  a_level_hold: assert property (int_rst_out |-> analog_out_level_out != 2'h2)
    else $error("data level during reset");
  a_sync_rst: assert property (!clk_sync_out [*2] |-> int_rst_out)
    else $error("reset released without lock");
  a_quad_filter: assert property ((ratio_valid_out && clk_ratio_out < 11'h100) [*3] |-> quad_filter_out)
    else $error("quad filter missing");
  a_quad_fosr: assert property (quad_filter_out [*2] |-> filter_osr_out == 4'h4)
    else $error("filter ratio not four");
  a_quad_osr: assert property ((rate_mode_out == 2'h2) [*2] |-> oversample_ratio_out == 8'h20)
    else $error("quad modulator ratio wrong");
  a_release_len: assert property ($fell(int_rst_out) |-> wait_q >= RELEASE_CYCLES && wait_q <= RELEASE_CYCLES + 4)
    else $error("release count wrong");
endmodule // dcr_ctrl_checker

// ---- dv/dcr_audio_src.sv ----
// ==========================================
// Audio processor model driving clocks and data.
module dcr_audio_src #(
  parameter real SCK_HALF_NS = 4.6
) (
  // Bench control
  input wire logic run_in,
  input wire logic [10:0] ratio_in,
  input wire logic [3:0] pattern_in,
  // Pins
  output logic sys_clk_out,
  output logic bit_clk_out,
  output logic frame_clk_out,
  output logic [3:0] data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  // Frame rises once every ratio_in system clock rises, on a falling edge.
  initial begin
    sys_clk_out = 1'b0;
    frame_clk_out = 1'b0;
    data_out = 4'h0;
    forever begin
      #(SCK_HALF_NS);
      if (run_in) begin
        sys_clk_out = ~sys_clk_out;
        if (!sys_clk_out) begin
          cnt = (cnt + 1 >= ratio_in) ? 0 : cnt + 1;
          frame_clk_out = (cnt < ratio_in / 2);
          data_out = pattern_in;
        end
      end
    end
  end
  // Bit clock stands still while frames are stopped.
  initial begin
    bit_clk_out = 1'b0;
    forever #62.5 bit_clk_out = run_in & ~bit_clk_out;
  end
endmodule // dcr_audio_src

// ---- dv/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, ext_rst_n_in = 1'b1, run = 1'b1;
  logic [1:0] force_mode_in = 2'h0;
  logic [10:0] ratio = 11'h080;
  logic [3:0] pat = 4'h5;
  wire sys_clk_in, serial_bit_clk_in, frame_clk_in, ratio_valid_out, quad_filter_out;
  wire clk_sync_out, int_rst_out, power_down_out;
  wire [3:0] din, filter_osr_out;
  wire [10:0] clk_ratio_out;
  wire [1:0] rate_mode_out, analog_out_level_out;
  wire [7:0] oversample_ratio_out, conv_data_out;
  int num_errors = 0;
  int n_checks = 0;
  initial forever #2 clk_in = ~clk_in;
  dcr_audio_src i_src (.run_in(run), .ratio_in(ratio), .pattern_in(pat), .sys_clk_out(sys_clk_in),
    .bit_clk_out(serial_bit_clk_in), .frame_clk_out(frame_clk_in), .data_out(din));
  dcr_ctrl #(.RELEASE_CYCLES(20)) i_dut (.clk_in, .sys_rst_in, .sys_clk_in, .serial_bit_clk_in, .frame_clk_in,
    .serial_data_in_1_in(din[0]), .serial_data_in_2_in(din[1]), .serial_data_in_3_in(din[2]),
    .serial_data_in_4_in(din[3]), .ext_rst_n_in, .force_mode_in, .clk_ratio_out, .ratio_valid_out,
    .rate_mode_out, .oversample_ratio_out, .filter_osr_out, .quad_filter_out, .clk_sync_out, .int_rst_out,
    .power_down_out, .analog_out_level_out, .conv_data_out);
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Waits for locked and running, or for unlocked and held in reset.
  task automatic wait_lock(input logic want);
    int i;
    for (i = 0; i < 40000 && (clk_sync_out !== want || int_rst_out !== !want); i++) tick();
    if (i == 40000) begin
      num_errors++;
      $display("mismatch lock expected %0b seen %0b", want, clk_sync_out);
      results();
    end
  endtask
  task automatic t_modes;
    logic [10:0] rt [7] = '{11'h080, 11'h0C0, 11'h100, 11'h180, 11'h200, 11'h300, 11'h480};
    logic [1:0] m;
    logic q;
    for (int r = 0; r < 7; r++) begin
      ratio = rt[r];
      pat = 4'h5 ^ r[3:0];
      force_mode_in = 2'h0;
      wait_lock(1'b0);
      wait_lock(1'b1);
      chk("ratio", rt[r], clk_ratio_out);
      chk("valid", 1, ratio_valid_out);
      chk("level", 2, analog_out_level_out);
      chk("conv", {{2{pat[3]}}, {2{pat[2]}}, {2{pat[1]}}, {2{pat[0]}}}, conv_data_out);
      q = rt[r] < 11'h100;
      for (int f = 0; f < 4; f++) begin
        force_mode_in = f[1:0];
        repeat (8) tick();
        m = q ? 2'h2 : (rt[r] < 11'h200) ? 2'h1 : 2'h0;
        if (f == 1 || (f == 2 && rt[r] < 11'h200) || (f == 3 && q)) m = f[1:0] - 2'h1;
        chk("mode", m, rate_mode_out);
        chk("osr", m == 2'h2 ? 8'h20 : (m == 2'h1 || q) ? 8'h40 : 8'h80, oversample_ratio_out);
        chk("filter", q ? 4'h4 : 4'h8, filter_osr_out);
        chk("quad", q, quad_filter_out);
      end
    end
    $display("test modes done");
  endtask
  task automatic t_ext_reset;
    ext_rst_n_in = 1'b0;
    repeat (4) tick();
    chk("ground", 0, analog_out_level_out);
    chk("int_rst", 1, int_rst_out);
    chk("pdown", 1, power_down_out);
    chk("sync_kept", 1, clk_sync_out);
    chk("conv_rst", 0, conv_data_out);
    ext_rst_n_in = 1'b1;
    repeat (4) tick();
    chk("common", 1, analog_out_level_out);
    wait_lock(1'b1);
    chk("rerun", 2, analog_out_level_out);
    chk("pdown_run", 0, power_down_out);
    $display("test ext_reset done");
  endtask
  task automatic t_clock_loss;
    run = 1'b0;
    wait_lock(1'b0);
    chk("held", 1, analog_out_level_out);
    chk("pdown_lost", 1, power_down_out);
    ratio = 11'h12C;
    run = 1'b1;
    repeat (3000) tick();
    chk("bad_ratio", 0, ratio_valid_out);
    chk("rst_bad", 1, int_rst_out);
    ratio = 11'h180;
    wait_lock(1'b1);
    chk("regain", 2, analog_out_level_out);
    $display("test clock_loss done");
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    t_modes();
    t_ext_reset();
    t_clock_loss();
    results();
  end
endmodule // tb
bind dcr_ctrl dcr_ctrl_checker #(.RELEASE_CYCLES(RELEASE_CYCLES)) i_chk (.clk_in, .sys_rst_in, .ext_rst_n_in,
  .clk_ratio_out, .ratio_valid_out, .rate_mode_out, .oversample_ratio_out, .filter_osr_out, .quad_filter_out,
  .clk_sync_out, .int_rst_out, .power_down_out, .analog_out_level_out);
